// *** hw/tw_pkg.sv ***
// constants and types shared by the two-wire slave-side controller
package tw_pkg;

  // ==========================================================================
  // bus framing
  localparam int unsigned   ADDR_W      = 7;
  localparam int unsigned   PTR_W       = 8;
  localparam int unsigned   DATA_W      = 8;
  localparam int unsigned   MEM_DEPTH   = 256;
  localparam logic [3:0]    BYTE_BITS   = 4'h8;
  localparam logic [2:0]    IDX_ADDR    = 3'h0;
  localparam logic [2:0]    IDX_PTR     = 3'h1;
  localparam logic [2:0]    IDX_WDATA0  = 3'h2;
  localparam logic [2:0]    MAX_BYTES   = 3'h4;
  localparam logic [2:0]    RD_BYTES    = 3'h2;
  localparam logic [ADDR_W-1:0] SLAVE_ADDR_DEF = 7'h2a;

  // ==========================================================================
  // link-side engine states
  typedef enum logic [2:0] {
    TW_IDLE,
    TW_RX,
    TW_ACK,
    TW_HOLD,
    TW_TX,
    TW_MACK,
    TW_WAIT_STOP
  } tw_state_t;

  // register offset of byte idx within a transfer
  function automatic logic [PTR_W-1:0] tw_offs(input logic [PTR_W-1:0] ptr, input logic [2:0] idx);
    tw_offs = ptr + {5'h00, idx};
  endfunction : tw_offs

endpackage : tw_pkg

// *** hw/tw_regmem.sv ***
// register memory of the slave, single port, registered read data
`timescale 1ns/10ps
module tw_regmem
  import tw_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              cen,
  input  wire logic              we,
  input  wire logic [PTR_W-1:0]  addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem [MEM_DEPTH];

  // ==========================================================================
  // storage
  always_ff @(posedge clk) begin
    if (cen) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end

endmodule : tw_regmem

// *** hw/tw_slave_ctl.sv ***
// two-wire slave-side controller: bus engine on the link clock, register memory on clk
//
// Functional notes
// - every byte is eight bits
// - read returns two data bytes after address
// - one acknowledge slot after every byte
// - bits travel most significant first
// - read returns pointer register, then pointer plus one
// - transmitter releases data line during acknowledge
// - receiver holds data low through acknowledge high
// - after read address, slave becomes transmitter
// - slave releases data line after not-acknowledge
// - slave may stretch clock low between bytes
// - data changes only while clock low
`timescale 1ns/10ps
module tw_slave_ctl
  import tw_pkg::*;
#(
  parameter logic [ADDR_W-1:0] SLAVE_ADDR = SLAVE_ADDR_DEF
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cen,
  input  wire logic              link_clk,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_n,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n,
  input  wire logic              usr_wr,
  input  wire logic              usr_rd,
  input  wire logic [PTR_W-1:0]  usr_addr,
  input  wire logic [DATA_W-1:0] usr_wdata,
  output logic                   usr_ack,
  output logic      [DATA_W-1:0] usr_rdata,
  output logic                   evt_wr,
  output logic      [PTR_W-1:0]  evt_wr_addr,
  output logic      [DATA_W-1:0] evt_wr_data
);

  // ==========================================================================
  // link domain: synchronisers
  logic scl_s1, scl_s2, scl_q;
  logic sda_s1, sda_s2, sda_q;
  logic lrst_s1, lrst;
  logic lcen_s1, lcen;
  logic ack_s1, ack_s2;
  logic ack_tgl_reg;

  always_ff @(posedge link_clk) begin
    scl_s1  <= scl_i;
    scl_s2  <= scl_s1;
    scl_q   <= scl_s2;
    sda_s1  <= sda_i;
    sda_s2  <= sda_s1;
    sda_q   <= sda_s2;
    lrst_s1 <= rst;
    lrst    <= lrst_s1;
    lcen_s1 <= cen;
    lcen    <= lcen_s1;
    ack_s1  <= ack_tgl_reg;
    ack_s2  <= ack_s1;
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s2 & ~scl_q;
  assign scl_fall  = ~scl_s2 & scl_q;
  assign bus_start = scl_s2 & scl_q & sda_q & ~sda_s2;
  assign bus_stop  = scl_s2 & scl_q & ~sda_q & sda_s2;

  // ==========================================================================
  // link domain: byte engine
  tw_state_t         state_reg;
  logic [3:0]        bit_cnt_reg;
  logic [2:0]        byte_idx_reg;
  logic [DATA_W-1:0] shift_reg;
  logic [DATA_W-1:0] tx_reg;
  logic [PTR_W-1:0]  ptr_reg;
  logic              rw_reg;
  logic              req_tgl_reg;
  logic              req_we_reg;
  logic [PTR_W-1:0]  req_addr_reg;
  logic [DATA_W-1:0] req_wdata_reg;
  logic [DATA_W-1:0] bus_rdata_reg;
  logic              pend;

  // a request is open until the memory side toggles back
  assign pend = req_tgl_reg ^ ack_s2;

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      state_reg     <= TW_IDLE;
      bit_cnt_reg   <= 4'h0;
      byte_idx_reg  <= 3'h0;
      shift_reg     <= 8'h00;
      tx_reg        <= 8'hff;
      ptr_reg       <= 8'h00;
      rw_reg        <= 1'b0;
      req_tgl_reg   <= 1'b0;
      req_we_reg    <= 1'b0;
      req_addr_reg  <= 8'h00;
      req_wdata_reg <= 8'h00;
      sda_oe_n      <= 1'b1;
      scl_oe_n      <= 1'b1;
      sda_o         <= 1'b0;
      scl_o         <= 1'b0;
    end else if (lcen) begin
      if (bus_stop) begin
        state_reg <= TW_IDLE;
        sda_oe_n  <= 1'b1;
        scl_oe_n  <= 1'b1;
      end else if (bus_start) begin
        // also covers a repeated start in mid-transfer
        state_reg    <= TW_RX;
        bit_cnt_reg  <= 4'h0;
        byte_idx_reg <= IDX_ADDR;
        sda_oe_n     <= 1'b1;
        scl_oe_n     <= 1'b1;
      end else begin
        case (state_reg)
          TW_IDLE: begin
          end
          TW_RX: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s2};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == BYTE_BITS) begin
              bit_cnt_reg  <= 4'h0;
              byte_idx_reg <= byte_idx_reg + 3'h1;
              if (byte_idx_reg == IDX_ADDR) begin
                if (shift_reg[7:1] == SLAVE_ADDR) begin
                  rw_reg    <= shift_reg[0];
                  sda_oe_n  <= 1'b0;
                  state_reg <= TW_ACK;
                  if (shift_reg[0]) begin
                    req_we_reg   <= 1'b0;
                    req_addr_reg <= tw_offs(ptr_reg, IDX_ADDR);
                    req_tgl_reg  <= ~req_tgl_reg;
                  end
                end else begin
                  state_reg <= TW_WAIT_STOP;
                end
              end else if (byte_idx_reg == IDX_PTR) begin
                ptr_reg   <= shift_reg;
                sda_oe_n  <= 1'b0;
                state_reg <= TW_ACK;
              end else if (byte_idx_reg < MAX_BYTES) begin
                req_we_reg    <= 1'b1;
                req_addr_reg  <= tw_offs(ptr_reg, byte_idx_reg - IDX_WDATA0);
                req_wdata_reg <= shift_reg;
                req_tgl_reg   <= ~req_tgl_reg;
                sda_oe_n      <= 1'b0;
                state_reg     <= TW_ACK;
              end else begin
                // a fifth byte is left unacknowledged
                state_reg <= TW_WAIT_STOP;
              end
            end
          end
          TW_ACK: begin
            if (scl_fall) begin
              sda_oe_n    <= 1'b1;
              bit_cnt_reg <= 4'h0;
              if (!rw_reg) begin
                state_reg <= TW_RX;
              end else if (pend) begin
                scl_oe_n  <= 1'b0;
                state_reg <= TW_HOLD;
              end else begin
                tx_reg    <= bus_rdata_reg;
                sda_oe_n  <= bus_rdata_reg[7];
                state_reg <= TW_TX;
              end
            end
          end
          TW_HOLD: begin
            // clock held low until the fetched byte is back
            if (!pend) begin
              tx_reg    <= bus_rdata_reg;
              sda_oe_n  <= bus_rdata_reg[7];
              scl_oe_n  <= 1'b1;
              state_reg <= TW_TX;
            end
          end
          TW_TX: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_reg == BYTE_BITS) begin
                sda_oe_n  <= 1'b1;
                state_reg <= TW_MACK;
              end else begin
                sda_oe_n <= tx_reg[6];
                tx_reg   <= {tx_reg[6:0], 1'b1};
              end
            end
          end
          TW_MACK: begin
            if (scl_rise) begin
              byte_idx_reg <= byte_idx_reg + 3'h1;
              if (!sda_s2 && byte_idx_reg < RD_BYTES) begin
                req_we_reg   <= 1'b0;
                req_addr_reg <= tw_offs(ptr_reg, byte_idx_reg);
                req_tgl_reg  <= ~req_tgl_reg;
                state_reg    <= TW_ACK;
              end else begin
                state_reg <= TW_WAIT_STOP;
              end
            end
          end
          TW_WAIT_STOP: begin
            sda_oe_n <= 1'b1;
          end
          default: begin
            state_reg <= TW_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // clk domain: request crossing and memory arbitration
  logic              req_s1, req_s2, req_s3;
  logic              bus_go;
  logic              bus_op_reg;
  logic              bus_we_reg;
  logic              usr_op_reg;
  logic              mem_we;
  logic [PTR_W-1:0]  mem_addr;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rdata;

  always_ff @(posedge clk) begin
    if (cen) begin
      req_s1 <= req_tgl_reg;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  // request words are held by the link side while the toggle is open
  assign bus_go = req_s2 ^ req_s3;

  // bus access wins; a colliding user request is dropped and must be retried
  always_comb begin
    if (bus_go) begin
      mem_we    = req_we_reg;
      mem_addr  = req_addr_reg;
      mem_wdata = req_wdata_reg;
    end else begin
      mem_we    = usr_wr;
      mem_addr  = usr_addr;
      mem_wdata = usr_wdata;
    end
  end

  tw_regmem u_mem (
    .clk   (clk),
    .cen   (cen),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  assign usr_rdata = mem_rdata;

  // ==========================================================================
  // clk domain: answers
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_op_reg    <= 1'b0;
      bus_we_reg    <= 1'b0;
      usr_op_reg    <= 1'b0;
      ack_tgl_reg   <= 1'b0;
      bus_rdata_reg <= 8'h00;
      usr_ack       <= 1'b0;
      evt_wr        <= 1'b0;
      evt_wr_addr   <= 8'h00;
      evt_wr_data   <= 8'h00;
    end else if (cen) begin
      bus_op_reg <= bus_go;
      bus_we_reg <= req_we_reg;
      usr_op_reg <= (usr_wr | usr_rd) & ~bus_go;
      usr_ack    <= usr_op_reg;
      evt_wr     <= bus_go & req_we_reg;
      if (bus_go && req_we_reg) begin
        evt_wr_addr <= req_addr_reg;
        evt_wr_data <= req_wdata_reg;
      end
      if (bus_op_reg) begin
        if (!bus_we_reg) begin
          bus_rdata_reg <= mem_rdata;
        end
        ack_tgl_reg <= ~ack_tgl_reg;
      end
    end
  end

endmodule : tw_slave_ctl

// *** testbench/tb.sv ***
// self-checking bench for the two-wire slave controller
`timescale 1ns/10ps
module tb;
  import tw_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, link_clk = 1'b0, fast = 1'b1, usr_wr = 1'b0, usr_rd = 1'b0, a;
  logic [7:0] usr_addr = 8'h00, usr_wdata = 8'h00, usr_rdata, evt_wr_addr, evt_wr_data, q;
  logic       scl_o, scl_oe_n, sda_o, sda_oe_n, usr_ack, evt_wr, m_scl_oe_n, m_sda_oe_n;
  wire        scl = scl_oe_n & m_scl_oe_n;
  wire        sda = sda_oe_n & m_sda_oe_n;
  int         failures = 0, compares = 0, evt_n = 0;
  always #20 clk = ~clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  always @(posedge clk) if (evt_wr === 1'b1) evt_n <= evt_n + 1;
  tw_slave_ctl dut_u (.clk(clk), .rst(rst), .cen(1'b1), .link_clk(link_clk), .scl_i(scl), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .usr_wr(usr_wr), .usr_rd(usr_rd),
    .usr_addr(usr_addr), .usr_wdata(usr_wdata), .usr_ack(usr_ack), .usr_rdata(usr_rdata), .evt_wr(evt_wr),
    .evt_wr_addr(evt_wr_addr), .evt_wr_data(evt_wr_data));
  tw_mstr m_u (.clk(clk), .fast(fast), .scl(scl), .sda(sda), .scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n));
  // ==========
  // shared steps
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic usr_op(input logic w, input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    usr_wr <= w;
    usr_rd <= !w;
    usr_addr <= ad;
    usr_wdata <= d;
    @(posedge clk);
    usr_wr <= 1'b0;
    usr_rd <= 1'b0;
    @(negedge clk);
    chk("ack early", 8'h00, usr_ack);
    @(negedge clk);
    chk("ack", 8'h01, usr_ack);
    q = usr_rdata;
  endtask : usr_op
  task automatic open_x(input logic [6:0] sa, input logic rd, input logic [7:0] e);
    m_u.cond(1'b1, 1'b0);
    m_u.wbyte({sa, rd}, a);
    chk("addr ack", e, a);
  endtask : open_x
  // ==========
  // scenarios
  task automatic t_user();
    usr_op(1'b1, 8'h10, 8'h5a);
    usr_op(1'b1, 8'h11, 8'ha5);
    usr_op(1'b0, 8'h10, 8'h00);
    chk("reg 10", 8'h5a, q);
    usr_op(1'b0, 8'h11, 8'h00);
    chk("reg 11", 8'ha5, q);
    $display("user port done");
  endtask : t_user
  task automatic t_write();
    logic [7:0] wd [4];
    int         n0;
    wd = '{8'h20, 8'hc3, 8'h3c, 8'h77};
    usr_op(1'b1, 8'h22, 8'h00);
    n0 = evt_n;
    open_x(SLAVE_ADDR_DEF, 1'b0, 8'h01);
    for (int i = 0; i < 4; i++) begin
      m_u.wbyte(wd[i], a);
      chk("write ack", {7'h00, i < 3}, a);
    end
    m_u.cond(1'b0, 1'b1);
    repeat (4) @(posedge clk);
    chk("events", 8'h02, 8'(evt_n - n0));
    chk("event addr", 8'h21, evt_wr_addr);
    chk("event data", 8'h3c, evt_wr_data);
    usr_op(1'b0, 8'h20, 8'h00);
    chk("reg 20", 8'hc3, q);
    usr_op(1'b0, 8'h21, 8'h00);
    chk("reg 21", 8'h3c, q);
    usr_op(1'b0, 8'h22, 8'h00);
    chk("reg 22", 8'h00, q);
    $display("bus write done");
  endtask : t_write
  // pass 0 sets the pointer and stops, pass 1 is the combined read
  task automatic t_read();
    logic [7:0] d;
    for (int k = 0; k < 2; k++) begin
      open_x(SLAVE_ADDR_DEF, 1'b0, 8'h01);
      m_u.wbyte(k ? 8'h20 : 8'h10, a);
      chk("ptr ack", 8'h01, a);
      if (k == 0) m_u.cond(1'b0, 1'b1);
      open_x(SLAVE_ADDR_DEF, 1'b1, 8'h01);
      m_u.rbyte(1'b0, d);
      chk("read 0", k ? 8'hc3 : 8'h5a, d);
      m_u.rbyte(1'b1, d);
      chk("read 1", k ? 8'h3c : 8'ha5, d);
      repeat (2) @(negedge clk);
      chk("sda free", 8'h01, sda);
      chk("pin levels", 8'h00, {6'h00, scl_o, sda_o});
      m_u.cond(1'b0, 1'b1);
    end
    $display("bus read done");
  endtask : t_read
  task automatic t_nack();
    fast <= 1'b0;
    open_x(SLAVE_ADDR_DEF ^ 7'h01, 1'b0, 8'h00);
    m_u.cond(1'b0, 1'b1);
    open_x(SLAVE_ADDR_DEF ^ 7'h01, 1'b0, 8'h00);
    open_x(SLAVE_ADDR_DEF, 1'b0, 8'h01);
    m_u.wbyte(8'h11, a);
    m_u.wbyte(8'h99, a);
    chk("data ack", 8'h01, a);
    m_u.cond(1'b0, 1'b1);
    fast <= 1'b1;
    usr_op(1'b0, 8'h11, 8'h00);
    chk("reg 11", 8'h99, q);
    $display("no-ack and standard mode done");
  endtask : t_nack
  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_user();
    t_write();
    t_read();
    t_nack();
    stop_test();
  end
  // tests need about 20k cycles; the limit allows five times that
  initial begin
    #4000000;
    failures++;
    stop_test();
  end
endmodule : tb

// *** testbench/tw_chk_properties.sv ***
// port checker for the two-wire slave controller
`timescale 1ns/10ps
module tw_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       link_clk,
  input wire logic       scl_i,
  input wire logic       scl_oe_n,
  input wire logic       sda_oe_n,
  input wire logic       usr_wr,
  input wire logic       usr_rd,
  input wire logic       usr_ack,
  input wire logic       evt_wr,
  input wire logic [7:0] evt_wr_addr,
  input wire logic [7:0] evt_wr_data
);
  // ==========
  // user port and events
  a_idle_after_rst: assert property (@(posedge clk) $fell(rst) |-> sda_oe_n && scl_oe_n && !usr_ack && !evt_wr)
    else $error("not idle after reset");
  a_ack_two_late: assert property (@(posedge clk) disable iff (rst) usr_ack |-> $past(usr_rd, 2) || $past(usr_wr, 2))
    else $error("ack without request");
  a_ack_one_cycle: assert property (@(posedge clk) disable iff (rst) usr_ack |=> !usr_ack)
    else $error("ack too long");
  a_evt_one_cycle: assert property (@(posedge clk) disable iff (rst) evt_wr |=> !evt_wr)
    else $error("event too long");
  a_evt_data_hold: assert property (@(posedge clk) disable iff (rst)
    !evt_wr |-> $stable(evt_wr_addr) && $stable(evt_wr_data)) else $error("event data moved");
  // ==========
  // link side; a stretch may end on the edge that sets the data bit
  a_sda_scl_low: assert property (@(posedge link_clk) disable iff (rst)
    $changed(sda_oe_n) && !$rose(scl_oe_n) |-> !scl_i) else $error("data moved in clock high");
  a_stretch_start: assert property (@(posedge link_clk) disable iff (rst) $fell(scl_oe_n) |-> !scl_i)
    else $error("stretch began in clock high");
  a_stretch_bound: assert property (@(posedge link_clk) disable iff (rst) $fell(scl_oe_n) |-> ##[1:60] scl_oe_n)
    else $error("stretch too long");
endmodule : tw_chk
bind tw_slave_ctl tw_chk chk_u (.clk(clk), .rst(rst), .link_clk(link_clk), .scl_i(scl_i), .scl_oe_n(scl_oe_n),
  .sda_oe_n(sda_oe_n), .usr_wr(usr_wr), .usr_rd(usr_rd), .usr_ack(usr_ack), .evt_wr(evt_wr),
  .evt_wr_addr(evt_wr_addr), .evt_wr_data(evt_wr_data));

// *** testbench/tw_mstr.sv ***
// two-wire bus master model facing the slave controller
`timescale 1ns/10ps
module tw_mstr (
  input  wire logic clk,
  input  wire logic fast,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe_n,
  output logic      sda_oe_n
);
  int lo;
  int hi;
  // ==========
  // phases in 40 ns cycles
  always_comb begin
    lo = fast ? 33 : 120;
    hi = fast ? 15 : 120;
  end
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  // ==========
  // bus steps, each entered just after a clk edge
  task automatic hi_phase();
    scl_oe_n <= 1'b1;
    @(posedge clk);
    while (scl !== 1'b1) @(posedge clk);
    repeat (hi) @(posedge clk);
  endtask : hi_phase
  task automatic bit_x(input logic b, output logic r);
    @(posedge clk);
    sda_oe_n <= b;
    repeat (lo) @(posedge clk);
    hi_phase();
    r = sda;
    scl_oe_n <= 1'b0;
  endtask : bit_x
  // a=1 b=0 gives start or repeated start, a=0 b=1 gives stop
  task automatic cond(input logic a, input logic b);
    @(posedge clk);
    sda_oe_n <= a;
    repeat (lo) @(posedge clk);
    hi_phase();
    sda_oe_n <= b;
    repeat (hi) @(posedge clk);
    if (!b) scl_oe_n <= 1'b0;
  endtask : cond
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask : rbyte
endmodule : tw_mstr
